// File: rtt_regs.svh
`ifndef RTT_REGS_SVH
`define RTT_REGS_SVH

// ---------------------------------------------------------------
// status nibble encodings
// ---------------------------------------------------------------
`define RTT_ST_CONTINUE   4'h0
`define RTT_ST_BEGIN      4'h1
`define RTT_ST_RSV_A      4'h2
`define RTT_ST_USER       4'h3
`define RTT_ST_PULSE_WDD  4'h4
`define RTT_ST_BRANCH     4'h5
`define RTT_ST_RSV_B      4'h6
`define RTT_ST_EXC_RET    4'h7
`define RTT_ST_MARK_HI    2'h2
`define RTT_ST_EXCEPTION  4'hc
`define RTT_ST_EMULATOR   4'hd
`define RTT_ST_STOPPED    4'he
`define RTT_ST_HALTED     4'hf

// ---------------------------------------------------------------
// widths and sizes
// ---------------------------------------------------------------
`define RTT_NIB_W         4
`define RTT_WORD_W        32
`define RTT_FIFO_DEPTH    2
`define RTT_BCNT_W        2
`define RTT_LEFT_W        4
`define RTT_NIB_IDLE      4'h0
`define RTT_ADDR_OFF      2'h0

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define RTT_MCLK_PERIOD_NS 20
`define RTT_MCLK_PER_PCYC  2

`endif

// File: rtt_pkg.sv
package rtt_pkg;

  // ---------------------------------------------------------------
  // kind of instruction starting in a processor cycle
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RTT_INSTR_NORMAL,
    RTT_INSTR_BRANCH,
    RTT_INSTR_PULSE,
    RTT_INSTR_WRITE_DEBUG_DATA_INSTR,
    RTT_INSTR_EXC_RET
  } rtt_instr_t;

  // ---------------------------------------------------------------
  // serializer state
  // ---------------------------------------------------------------
  typedef enum logic {
    RTT_SER_IDLE,
    RTT_SER_SHIFT
  } rtt_ser_t;

endpackage

// File: rtt_fifo.sv
`timescale 1ns/1ps

module rtt_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  import rtt_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // ---------------------------------------------------------------
  // pointers and fill level
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// File: rtt_trace_port.sv
// Overview of operation
// - two separate 4-bit outputs, one for status, one for captured data.
// - captured targets and operands pass a two-entry FIFO of 32-bit words.
// - each buffered value leaves one nibble per cycle, lowest nibble first.
// - core stalls while both FIFO entries wait and a capture is pending, and in each marker cycle; resumes when one frees.
// - later cycles of a multi-cycle instruction show status 0x0.
// - first cycle of most instructions shows 0x1; special ones use own codes.
// - status 0x3 follows an instruction that entered user mode.
// - pulse and debug-data-write show 0x4; write sends marker and operand only when capture_valid is set.
// - taken branch shows 0x5 and may capture its target address.
// - a marker on the status nibble gives the byte count of the value that follows: configured address size or operand size.
// - exception-return instruction start shows 0x7.
// - codes 0x8 to 0xB announce 1 to 4 data bytes.
// - marker appears exactly one cycle before the first data nibble.
// - ordinary exception processing holds 0xC until done.
// - emulator-mode entry holds 0xD until that processing completes.
// - after stop, 0xE holds until an interrupt ends the stop.
// - while halted, 0xF holds until restart or reset.
// - status nibble updates every processor cycle.
// - sample clock stays idle until first 0xC, 0xD or 0xF status.
// - full FIFO with pending capture stalls the pipeline showing 0x0.
// - multi-byte values go out least significant byte first.
`timescale 1ns/1ps
`include "rtt_regs.svh"

module rtt_trace_port #(
  parameter int DEPTH = `RTT_FIFO_DEPTH
) (
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  input  wire logic                       instr_start,
  input  wire rtt_pkg::rtt_instr_t        instr_kind,
  input  wire logic                       user_mode_entry,
  input  wire logic                       exc_active,
  input  wire logic                       emu_active,
  input  wire logic                       stopped,
  input  wire logic                       halted,
  input  wire logic                       capture_valid,
  input  wire logic [`RTT_WORD_W-1:0]     capture_data,
  input  wire logic [`RTT_BCNT_W-1:0]     operand_bytes_m1,
  input  wire logic [`RTT_BCNT_W-1:0]     addr_bytes_cfg,
  output logic      [`RTT_NIB_W-1:0]      processor_status_bus,
  output logic      [`RTT_NIB_W-1:0]      debug_data_bus,
  output logic                            status_sample_clock,
  output logic                            core_stall,
  output logic                            cycle_tick
);
  import rtt_pkg::*;

  localparam int FW = `RTT_WORD_W + `RTT_BCNT_W;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                    phase;
  logic                    started;
  logic                    mode_hold;
  logic                    cap_req;
  logic                    cap_stall;
  logic                    load_ok;
  logic                    ser_last;
  logic [`RTT_BCNT_W-1:0]  cap_bytes_m1;
  logic [`RTT_NIB_W-1:0]   core_code;
  logic [`RTT_NIB_W-1:0]   next_status;
  logic                    next_started;
  rtt_ser_t                ser_state;
  logic [`RTT_WORD_W-1:0]  shreg;
  logic [`RTT_LEFT_W-1:0]  left;
  logic [`RTT_LEFT_W-1:0]  fill_seen;
  logic                    fifo_in_valid;
  logic                    fifo_in_ready;
  logic [FW-1:0]           fifo_in_data;
  logic                    fifo_out_valid;
  logic                    fifo_out_ready;
  logic [FW-1:0]           fifo_out_data;
  logic [`RTT_BCNT_W-1:0]  head_bytes_m1;
  logic [`RTT_WORD_W-1:0]  head_word;

  // ---------------------------------------------------------------
  // processor cycle divider
  // ---------------------------------------------------------------
  // one processor cycle is two mclk periods; outputs move on the tick
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  assign cycle_tick = phase;

  // ---------------------------------------------------------------
  // capture request and stall
  // ---------------------------------------------------------------
  assign mode_hold = halted || emu_active || exc_active || stopped;

  always_comb begin
    cap_req      = 1'b0;
    cap_bytes_m1 = operand_bytes_m1;
    if (instr_start && capture_valid && !mode_hold) begin
      if (instr_kind == RTT_INSTR_WRITE_DEBUG_DATA_INSTR) begin
        cap_req      = 1'b1;
        cap_bytes_m1 = operand_bytes_m1;
      end else if (instr_kind == RTT_INSTR_BRANCH && addr_bytes_cfg != `RTT_ADDR_OFF) begin
        cap_req      = 1'b1;
        cap_bytes_m1 = addr_bytes_cfg;
      end
    end
  end

  assign head_word     = fifo_out_data[`RTT_WORD_W-1:0];
  assign head_bytes_m1 = fifo_out_data[FW-1:`RTT_WORD_W];
  assign ser_last      = (ser_state == RTT_SER_IDLE) || (left == `RTT_LEFT_W'(1));
  assign load_ok       = ser_last && fifo_out_valid && !mode_hold;
  assign cap_stall     = cap_req && !fifo_in_ready && !load_ok;
  assign core_stall    = load_ok || cap_stall;

  assign fifo_in_valid  = phase && cap_req && !load_ok;
  assign fifo_in_data   = {cap_bytes_m1, capture_data};
  assign fifo_out_ready = phase && ser_last && !mode_hold;

  rtt_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // status code from the core's state
  // ---------------------------------------------------------------
  always_comb begin
    core_code = `RTT_ST_CONTINUE;
    if (halted) begin
      core_code = `RTT_ST_HALTED;
    end else if (emu_active) begin
      core_code = `RTT_ST_EMULATOR;
    end else if (exc_active) begin
      core_code = `RTT_ST_EXCEPTION;
    end else if (stopped) begin
      core_code = `RTT_ST_STOPPED;
    end else if (cap_stall) begin
      core_code = `RTT_ST_CONTINUE;
    end else if (instr_start) begin
      unique case (instr_kind)
        RTT_INSTR_NORMAL:  core_code = `RTT_ST_BEGIN;
        RTT_INSTR_BRANCH:  core_code = `RTT_ST_BRANCH;
        RTT_INSTR_PULSE:   core_code = `RTT_ST_PULSE_WDD;
        RTT_INSTR_WRITE_DEBUG_DATA_INSTR:  core_code = `RTT_ST_PULSE_WDD;
        RTT_INSTR_EXC_RET: core_code = `RTT_ST_EXC_RET;
        default:           core_code = `RTT_ST_BEGIN;
      endcase
    end else if (user_mode_entry) begin
      core_code = `RTT_ST_USER;
    end
  end

  // marker takes the cycle, the core is held off meanwhile
  assign next_status = load_ok ? {`RTT_ST_MARK_HI, head_bytes_m1} : core_code;

  // ---------------------------------------------------------------
  // status nibble register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      processor_status_bus <= `RTT_ST_CONTINUE;
    end else if (phase) begin
      processor_status_bus <= next_status;
    end
  end

  // ---------------------------------------------------------------
  // data serializer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ser_state      <= RTT_SER_IDLE;
      shreg          <= '0;
      left           <= '0;
      debug_data_bus <= `RTT_NIB_IDLE;
    end else if (phase) begin
      if (ser_state == RTT_SER_SHIFT) begin
        debug_data_bus <= shreg[`RTT_NIB_W-1:0];
        shreg          <= shreg >> `RTT_NIB_W;
        left           <= left - 1'b1;
      end else begin
        debug_data_bus <= `RTT_NIB_IDLE;
      end
      if (load_ok) begin
        shreg     <= head_word;
        left      <= {1'b0, head_bytes_m1, 1'b0} + `RTT_LEFT_W'(2);
        ser_state <= RTT_SER_SHIFT;
      end else if (ser_state == RTT_SER_SHIFT && left == `RTT_LEFT_W'(1)) begin
        ser_state <= RTT_SER_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // sample clock
  // ---------------------------------------------------------------
  assign next_started = started || (phase && (next_status == `RTT_ST_EXCEPTION ||
                                              next_status == `RTT_ST_EMULATOR ||
                                              next_status == `RTT_ST_HALTED));

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      started <= 1'b0;
    end else begin
      started <= next_started;
    end
  end

  // rises mid-way between two status updates
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      status_sample_clock <= 1'b0;
    end else begin
      status_sample_clock <= started && !phase;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // fill level counted apart from the fifo's own flags
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fill_seen <= '0;
    end else begin
      fill_seen <= fill_seen + `RTT_LEFT_W'(fifo_in_valid && fifo_in_ready)
                             - `RTT_LEFT_W'(fifo_out_valid && fifo_out_ready);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_no_reserved;
    processor_status_bus != `RTT_ST_RSV_A && processor_status_bus != `RTT_ST_RSV_B;
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved status code driven");

  property p_update_on_tick;
    !phase |=> $stable(processor_status_bus) && $stable(debug_data_bus);
  endproperty
  a_update_on_tick: assert property (p_update_on_tick)
    else $error("trace outputs moved between processor cycles");

  property p_marker_code;
    phase && load_ok |=> processor_status_bus == {2'h2, $past(head_bytes_m1)};
  endproperty
  a_marker_code: assert property (p_marker_code)
    else $error("marker does not match byte count");

  property p_marker_lead;
    phase && load_ok |-> ##3 debug_data_bus == $past(head_word[3:0], 3);
  endproperty
  a_marker_lead: assert property (p_marker_lead)
    else $error("first nibble not one cycle after marker");

  property p_lsn_order;
    phase && ser_state == RTT_SER_SHIFT |=> debug_data_bus == $past(shreg[3:0]);
  endproperty
  a_lsn_order: assert property (p_lsn_order)
    else $error("nibble order wrong");

  property p_stall_only_full;
    core_stall && !load_ok |-> fill_seen == `RTT_LEFT_W'(DEPTH);
  endproperty
  a_stall_only_full: assert property (p_stall_only_full)
    else $error("stall without full fifo");

  property p_stall_free;
    cap_req && !load_ok && fill_seen != `RTT_LEFT_W'(DEPTH) |-> !core_stall;
  endproperty
  a_stall_free: assert property (p_stall_free)
    else $error("stall although a fifo entry is free");

  property p_stall_shows_zero;
    phase && cap_stall |=> processor_status_bus == 4'h0;
  endproperty
  a_stall_shows_zero: assert property (p_stall_shows_zero)
    else $error("stalled cycle not shown as continue");

  property p_halt_code;
    phase && halted && !load_ok |=> processor_status_bus == 4'hf ##1 $stable(processor_status_bus);
  endproperty
  a_halt_code: assert property (p_halt_code)
    else $error("halt not shown");

  property p_clock_idle;
    !started |=> !status_sample_clock;
  endproperty
  a_clock_idle: assert property (p_clock_idle)
    else $error("sample clock ran before start");

  property p_branch_code;
    phase && instr_start && instr_kind == RTT_INSTR_BRANCH && !mode_hold && !core_stall
      |=> processor_status_bus == 4'h5;
  endproperty
  a_branch_code: assert property (p_branch_code)
    else $error("taken branch not shown");

  property p_begin_code;
    phase && instr_start && instr_kind == RTT_INSTR_NORMAL && !mode_hold && !core_stall
      |=> processor_status_bus == 4'h1;
  endproperty
  a_begin_code: assert property (p_begin_code)
    else $error("instruction start not shown");

  property p_user_code;
    phase && user_mode_entry && !instr_start && !mode_hold && !load_ok
      |=> processor_status_bus == 4'h3;
  endproperty
  a_user_code: assert property (p_user_code)
    else $error("user mode entry not shown");

  property p_exc_code;
    phase && exc_active && !halted && !emu_active |=> processor_status_bus == 4'hc;
  endproperty
  a_exc_code: assert property (p_exc_code)
    else $error("exception processing not shown");

  property p_clock_runs;
    started && phase |=> !status_sample_clock ##1 status_sample_clock;
  endproperty
  a_clock_runs: assert property (p_clock_runs)
    else $error("sample clock not running after start");

  cover property (phase && load_ok && ser_state == RTT_SER_SHIFT);
  cover property (phase && cap_stall);
  cover property (phase && instr_start && instr_kind == RTT_INSTR_WRITE_DEBUG_DATA_INSTR && cap_req);
  cover property (phase && halted);

endmodule

// File: rtt_trace_sampler.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// development system side: samples status and data on the sample clock
// ---------------------------------------------------------------
module rtt_trace_sampler (
  input wire logic       status_sample_clock,
  input wire logic [3:0] processor_status_bus,
  input wire logic [3:0] debug_data_bus
);
  logic [31:0] words[$];
  logic [31:0] acc       = 32'h0;
  int          left      = 0;
  int          pos       = 0;
  int          bad_codes = 0;

  always @(posedge status_sample_clock) begin
    if (processor_status_bus === 4'h2 || processor_status_bus === 4'h6) begin
      bad_codes++;
    end
    // data nibble first: a new marker may overlap the last nibble of a word
    if (left > 0) begin
      acc[4*pos +: 4] = debug_data_bus;
      pos++;
      left--;
      if (left == 0) begin
        words.push_back(acc);
      end
    end
    if (processor_status_bus[3:2] === 2'h2) begin
      left = 2 * (int'(processor_status_bus[1:0]) + 1);
      pos  = 0;
      acc  = 32'h0;
    end
  end
endmodule

// File: rtt_trace_port_bench.sv
`timescale 1ns/1ps

module rtt_trace_port_bench;
  import rtt_pkg::*;

  logic        mclk             = 1'b0;
  logic        rstn             = 1'b0;
  logic        instr_start      = 1'b0;
  rtt_instr_t  instr_kind       = RTT_INSTR_NORMAL;
  logic        user_mode_entry  = 1'b0;
  logic        exc_active       = 1'b0;
  logic        emu_active       = 1'b0;
  logic        stopped          = 1'b0;
  logic        halted           = 1'b0;
  logic        capture_valid    = 1'b0;
  logic [31:0] capture_data     = 32'h0;
  logic [1:0]  operand_bytes_m1 = 2'h0;
  logic [1:0]  addr_bytes_cfg   = 2'h0;
  logic [3:0]  processor_status_bus;
  logic [3:0]  debug_data_bus;
  logic        status_sample_clock;
  logic        core_stall;
  logic        cycle_tick;
  int          err_count        = 0;
  int          num_checks       = 0;
  logic        waited           = 1'b0;

  always #10 mclk = ~mclk;

  rtt_trace_port dut (
    .mclk                (mclk),
    .rstn                (rstn),
    .instr_start         (instr_start),
    .instr_kind          (instr_kind),
    .user_mode_entry     (user_mode_entry),
    .exc_active          (exc_active),
    .emu_active          (emu_active),
    .stopped             (stopped),
    .halted              (halted),
    .capture_valid       (capture_valid),
    .capture_data        (capture_data),
    .operand_bytes_m1    (operand_bytes_m1),
    .addr_bytes_cfg      (addr_bytes_cfg),
    .processor_status_bus(processor_status_bus),
    .debug_data_bus      (debug_data_bus),
    .status_sample_clock (status_sample_clock),
    .core_stall          (core_stall),
    .cycle_tick          (cycle_tick)
  );

  rtt_trace_sampler smp (
    .status_sample_clock (status_sample_clock),
    .processor_status_bus(processor_status_bus),
    .debug_data_bus      (debug_data_bus)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    if (err_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  function automatic logic [31:0] bmask(input int bytes);
    return (bytes == 4) ? 32'hffffffff : (32'h1 << (8 * bytes)) - 32'h1;
  endfunction

  // hold the request until a tick edge takes it, return at the next falling edge
  task automatic issue(input rtt_instr_t kind, input logic cap, input logic [31:0] data,
                       input logic [1:0] opm1);
    int   n;
    logic full_stall;
    n                = 0;
    full_stall       = 1'b0;
    instr_start      = 1'b1;
    instr_kind       = kind;
    capture_valid    = cap;
    capture_data     = data;
    operand_bytes_m1 = opm1;
    #1;
    while (!(cycle_tick === 1'b1 && core_stall === 1'b0) && n < 40) begin
      full_stall = (cycle_tick === 1'b1 && core_stall === 1'b1);
      @(negedge mclk);
      #1;
      if (full_stall && processor_status_bus === 4'h0) begin
        waited = 1'b1;
      end
      n++;
    end
    if (n >= 40) begin
      err_count++;
      final_report();
    end
    @(negedge mclk);
  endtask

  task automatic idle();
    instr_start   = 1'b0;
    capture_valid = 1'b0;
  endtask

  task automatic word_chk(input logic [31:0] exp);
    int n;
    n = 0;
    while (smp.words.size() == 0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400) begin
      err_count++;
      final_report();
    end
    chk("trace word", smp.words.pop_front(), exp);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset_start();
    int highs;
    int ticks;
    chk("status after reset", processor_status_bus, 32'h0);
    chk("data after reset", debug_data_bus, 32'h0);
    highs = 0;
    ticks = 0;
    repeat (16) begin
      @(negedge mclk);
      highs += int'(status_sample_clock === 1'b1);
      ticks += int'(cycle_tick === 1'b1);
    end
    chk("idle sample clock", highs, 32'h0);
    chk("processor cycle ticks", ticks, 32'h8);
    exc_active = 1'b1;
    tick(4);
    chk("exception status", processor_status_bus, 32'hc);
    highs = 0;
    repeat (8) begin
      @(negedge mclk);
      highs += int'(status_sample_clock === 1'b1);
    end
    chk("running sample clock", highs, 32'h4);
    chk("exception held", processor_status_bus, 32'hc);
    exc_active = 1'b0;
    tick(4);
  endtask

  task automatic sc_modes();
    logic [4:0] m[7] = '{5'b10000, 5'b01000, 5'b00100, 5'b00010, 5'b00001,
                         5'b11111, 5'b01110};
    logic [3:0] e[7] = '{4'hf, 4'hd, 4'hc, 4'he, 4'h3, 4'hf, 4'hd};
    for (int i = 0; i < 7; i++) begin
      {halted, emu_active, exc_active, stopped, user_mode_entry} = m[i];
      tick(3);
      chk("mode status", processor_status_bus, e[i]);
      tick(6);
      chk("mode status held", processor_status_bus, e[i]);
      {halted, emu_active, exc_active, stopped, user_mode_entry} = 5'b0;
      tick(3);
    end
  endtask

  task automatic sc_codes();
    rtt_instr_t k[4] = '{RTT_INSTR_NORMAL, RTT_INSTR_PULSE, RTT_INSTR_EXC_RET,
                         RTT_INSTR_BRANCH};
    logic [3:0] e[4] = '{4'h1, 4'h4, 4'h7, 4'h5};
    for (int i = 0; i < 4; i++) begin
      issue(k[i], 1'b0, 32'h0, 2'h0);
      idle();
      chk("begin status", processor_status_bus, e[i]);
      tick(2);
      chk("following status", processor_status_bus, 32'h0);
    end
  endtask

  task automatic sc_wdd();
    logic [1:0]  m[3] = '{2'h0, 2'h1, 2'h3};
    logic [31:0] d    = 32'h8c4a2e61;
    for (int i = 0; i < 3; i++) begin
      issue(RTT_INSTR_WRITE_DEBUG_DATA_INSTR, 1'b1, d, m[i]);
      idle();
      chk("write status", processor_status_bus, 32'h4);
      tick(2);
      chk("write marker", processor_status_bus, 32'h8 + m[i]);
      word_chk(d & bmask(int'(m[i]) + 1));
      d = ~d;
    end
  endtask

  task automatic sc_branch();
    logic [31:0] d = 32'h3b9f07d5;
    for (int c = 0; c < 4; c++) begin
      addr_bytes_cfg = c[1:0];
      issue(RTT_INSTR_BRANCH, 1'b1, d, 2'h0);
      idle();
      chk("branch status", processor_status_bus, 32'h5);
      tick(2);
      chk("branch marker", processor_status_bus, (c == 0) ? 32'h0 : 32'h8 + c);
      if (c != 0) begin
        word_chk(d & bmask(c + 1));
      end
      d = {d[15:0], d[31:16]} ^ 32'h5a5a0ff0;
    end
    addr_bytes_cfg = 2'h0;
  endtask

  task automatic sc_stall();
    logic [31:0] d[4] = '{32'h11f2e3d4, 32'hc5b6a798, 32'h0e1d2c3b, 32'h7a695847};
    waited = 1'b0;
    for (int i = 0; i < 3; i++) begin
      issue(RTT_INSTR_WRITE_DEBUG_DATA_INSTR, 1'b1, d[i], 2'h3);
    end
    chk("stall with free entry", waited, 32'h0);
    issue(RTT_INSTR_WRITE_DEBUG_DATA_INSTR, 1'b1, d[3], 2'h3);
    idle();
    chk("core held back", waited, 32'h1);
    for (int i = 0; i < 4; i++) begin
      word_chk(d[i]);
    end
    chk("reserved codes", smp.bad_codes, 32'h0);
  endtask

  initial begin
    repeat (4) @(negedge mclk);
    rstn = 1'b1;
    tick(2);
    sc_reset_start();
    sc_modes();
    sc_codes();
    sc_wdd();
    sc_branch();
    sc_stall();
    tick(4);
    final_report();
  end
endmodule
